// ---- pssr_pkg.sv ----
/*
 * Constants, field layouts and carrier types of the per-port status bank.
 * Assumes a byte-addressed register port with 32-bit read data.
 */
`default_nettype none

package pssr_pkg;

  // Register offsets, kept as printed byte offsets of the status page.
  localparam logic [7:0] OFF_LINK = 8'h00;
  localparam logic [7:0] OFF_CHG = 8'h02;
  localparam logic [7:0] OFF_SPEED = 8'h04;
  localparam logic [7:0] OFF_DUPLEX = 8'h08;
  localparam logic [7:0] OFF_PAUSE = 8'h0A;
  localparam logic [7:0] OFF_SACHG = 8'h0E;
  localparam logic [7:0] OFF_LASTSA = 8'h10;
  localparam logic [7:0] LASTSA_STRIDE = 8'h06;
  localparam logic [7:0] LASTSA_HI = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h80;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h84;
  localparam logic [7:0] OFF_SER_LO = 8'hF0;
  localparam logic [7:0] OFF_SER_HI = 8'hF4;
  localparam logic [7:0] OFF_SER_STAT = 8'hFE;
  localparam logic [7:0] OFF_PAGE = 8'hFF;

  // Port layout: bit 8 is the management port, bits 7:6 are unused.
  localparam int NPORT = 9;
  localparam int MGMT = 8;
  localparam int TURBO_PORT = 5;
  localparam logic [8:0] PORT_MASK = 9'h13F;
  localparam logic [8:0] SACHG_MASK = 9'h11F;
  localparam logic [8:0] CHG_RESET = 9'h1FF;
  localparam logic [8:0] SACHG_RESET = 9'h000;
  localparam int SPEED_MGMT_LSB = 16;
  localparam int RX_PAUSE_LSB = 9;

  // Two-bit rate codes.
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [1:0] SPD_200 = 2'h3;

  // Interrupt status and mask layout.
  localparam int IRQ_W = 2;
  localparam int IRQ_LINK = 0;
  localparam int IRQ_SA = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // Live port state; turbo bits: index 0 is port 5, index 1 the management port.
  typedef struct packed {
    logic [8:0] link;
    logic [8:0] duplex;
    logic [8:0] rx_pause;
    logic [8:0] tx_pause;
    logic [8:0][1:0] speed;
    logic [1:0] turbo_mii_mode;
    logic [1:0] reverse_turbo_mii_mode;
  } pssr_port_state_t;

  // One register access from software.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pssr_bus_req_t;

  // Global serial access registers mirrored on this page.
  typedef struct packed {
    logic [63:0] data;
    logic [7:0] status;
    logic [7:0] page;
  } pssr_serial_view_t;

  typedef logic [8:0][47:0] pssr_last_sa_t;

endpackage : pssr_pkg

`default_nettype wire

// ---- pssr_rc_flags.sv ----
/*
 * Bank of sticky flags that hardware sets and a clear strobe drops.
 * Assumes set and clear come from logic on the same clock.
 */
`default_nettype none

module pssr_rc_flags #(
  parameter int W = 9,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // A set in the clearing cycle wins, so no event is lost.
  always_comb begin
    q_next = (q_reg & ~clr) | set;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q_reg <= RST;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

  a_set_wins: assert property (@(posedge clk) disable iff (!nrst)
    |set |=> (q_reg & $past(set)) == $past(set))
    else $error("A set flag was lost.");
endmodule : pssr_rc_flags

`default_nettype wire

// ---- pssr_status_bank.sv ----
/*
 * Per-port status register bank of the switch status page.
 * Assumes live port state arrives from other clock domains, while source
 * address events and values come from logic on clk.
 */
//
// Overview of operation
// (RULE_01) Link reads one bit per port, bit 8 management, 7:6 zero, 1 is link pass.
// (RULE_02) A link change sets a sticky bit that only a read of the change register clears.
// (RULE_03) A change bit of 1 means the link changed, and all nine bits read one after reset.
// (RULE_04) Speed is two bits per port, management at 17:16, 15:12 zero, port n at 2n+1:2n.
// (RULE_05) Speed codes are 00 for 10, 01 for 100 and 10 for 1000 Mbps.
// (RULE_06) Code 11 means 200 Mbps and shows only on port 5 or management in a turbo mode.
// (RULE_07) Duplex reads one bit per port in the link layout, 1 is full duplex.
// (RULE_08) Receive pause sits in 17:9, management at 17, 16:15 zero, 1 is enabled.
// (RULE_09) Transmit pause sits in 8:0, management at 8, 7:6 zero, 1 is enabled.
// (RULE_10) Upper unused bits of speed and pause read zero and software writes them as zero.
// (RULE_11) Last source addresses sit at 10h-45h, six bytes a port, change flags at 0Eh.
// (RULE_12) The global serial data, serial status and page bytes show at F0h-F7h, FEh and FFh.
// (RULE_13) A new source address on a port sets a sticky bit that a read clears; the code never sets the bits of ports 5 to 7.
// (RULE_14) Link, speed, duplex and pause fields follow the live port state at all times.
`default_nettype none

module pssr_status_bank (
  input wire logic clk,
  input wire logic nrst,
  input wire pssr_pkg::pssr_bus_req_t bus_req,
  output logic [31:0] rdata,
  input wire pssr_pkg::pssr_port_state_t port_state,
  input wire logic [8:0] new_source_seen,
  input wire pssr_pkg::pssr_last_sa_t last_sa,
  input wire pssr_pkg::pssr_serial_view_t serial_view,
  output logic irq
);
  import pssr_pkg::*;

  localparam int SW = $bits(pssr_port_state_t);

  ////////////////////////////////////////////////////////////////////////////
  // Live state capture.

  logic [SW-1:0] st_vec;
  pssr_port_state_t st;
  logic [8:0] link_view;
  logic [8:0] duplex_view;
  logic [8:0] rxp_view;
  logic [8:0] txp_view;
  logic [17:0] speed_view;

  // Port state crosses into clk before anything looks at it.
  pssr_sync2 #(.W(SW)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d(port_state),
    .q(st_vec)
  );

  assign st = pssr_port_state_t'(st_vec);

  // Maps a raw rate to the reported code; 200 Mbps only where turbo is allowed.
  function automatic logic [1:0] rate_code(input logic [1:0] raw, input logic turbo);
    logic [1:0] code;
    code = raw;
    if (turbo) begin
      code = SPD_200; // see RULE_06
    end else if (raw == SPD_200) begin
      code = SPD_1000; // see RULE_06
    end
    return code;
  endfunction : rate_code

  // Summary fields follow the synchronised state with no holding register.
  always_comb begin
    link_view = st.link & PORT_MASK; // see RULE_01, see RULE_14
    duplex_view = st.duplex & PORT_MASK; // see RULE_07, see RULE_14
    rxp_view = st.rx_pause & PORT_MASK; // see RULE_08, see RULE_14
    txp_view = st.tx_pause & PORT_MASK; // see RULE_09, see RULE_14
    speed_view = '0;
    for (int p = 0; p < TURBO_PORT; p++) begin
      speed_view[2*p +: 2] = rate_code(st.speed[p], 1'b0); // see RULE_04, see RULE_05
    end
    speed_view[2*TURBO_PORT +: 2] = rate_code(st.speed[TURBO_PORT],
      st.turbo_mii_mode[0] | st.reverse_turbo_mii_mode[0]); // see RULE_06
    speed_view[SPEED_MGMT_LSB +: 2] = rate_code(st.speed[MGMT],
      st.turbo_mii_mode[1] | st.reverse_turbo_mii_mode[1]); // see RULE_04, see RULE_06
  end

  ////////////////////////////////////////////////////////////////////////////
  // Change detection and sticky flags.

  logic [8:0] link_prev_reg;
  logic [8:0] link_prev_next;
  logic primed_reg;
  logic primed_next;
  logic rd_chg;
  logic rd_sachg;
  logic [8:0] chg_set;
  logic [8:0] chg_flags;
  logic [8:0] sa_set;
  logic [8:0] sa_flags;

  // The first cycle after reset only records the link state, so no false edge.
  always_comb begin
    link_prev_next = link_view;
    primed_next = 1'b1;
    rd_chg = bus_req.rd && (bus_req.addr == OFF_CHG);
    rd_sachg = bus_req.rd && (bus_req.addr == OFF_SACHG);
    chg_set = primed_reg ? (link_view ^ link_prev_reg) : '0; // see RULE_02
    sa_set = new_source_seen & SACHG_MASK; // see RULE_13
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      link_prev_reg <= '0;
      primed_reg <= 1'b0;
    end else begin
      link_prev_reg <= link_prev_next;
      primed_reg <= primed_next;
    end
  end

  // Link change flags start all ones and clear on a read of their register.
  pssr_rc_flags #(.W(NPORT), .RST(CHG_RESET)) u_chg (
    .clk(clk),
    .nrst(nrst),
    .set(chg_set),
    .clr({NPORT{rd_chg}}), // see RULE_02, see RULE_03
    .q(chg_flags)
  );

  // Source address change flags clear on a read of their register.
  pssr_rc_flags #(.W(NPORT), .RST(SACHG_RESET)) u_sachg (
    .clk(clk),
    .nrst(nrst),
    .set(sa_set),
    .clr({NPORT{rd_sachg}}), // see RULE_13
    .q(sa_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask.

  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_mask_next;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_w1c;

  // Events set sticky bits; writing one clears them, and a new event wins.
  always_comb begin
    irq_event = '0;
    irq_event[IRQ_LINK] = |chg_set;
    irq_event[IRQ_SA] = |sa_set;
    irq_w1c = '0;
    irq_mask_next = irq_mask_reg;
    if (bus_req.wr && (bus_req.addr == OFF_IRQ_STAT)) begin
      irq_w1c = bus_req.wdata[IRQ_W-1:0];
    end
    if (bus_req.wr && (bus_req.addr == OFF_IRQ_MASK)) begin
      irq_mask_next = bus_req.wdata[IRQ_W-1:0];
    end
    irq_stat_next = (irq_stat_reg & ~irq_w1c) | irq_event;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_stat_reg <= IRQ_RESET;
      irq_mask_reg <= IRQ_RESET;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Read path; writes are ignored except at the interrupt status and mask registers.

  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Read data stand for exactly the cycle after the read strobe.
  always_comb begin
    rdata_next = '0;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFF_LINK: rdata_next = {23'h0, link_view}; // see RULE_01
        OFF_CHG: rdata_next = {23'h0, chg_flags}; // see RULE_02, see RULE_03
        OFF_SPEED: rdata_next = {14'h0, speed_view}; // see RULE_04, see RULE_10
        OFF_DUPLEX: rdata_next = {23'h0, duplex_view}; // see RULE_07
        OFF_PAUSE: rdata_next = {14'h0, rxp_view, txp_view}; // see RULE_08, see RULE_09, see RULE_10
        OFF_SACHG: rdata_next = {23'h0, sa_flags}; // see RULE_13
        OFF_IRQ_STAT: rdata_next = {30'h0, irq_stat_reg};
        OFF_IRQ_MASK: rdata_next = {30'h0, irq_mask_reg};
        OFF_SER_LO: rdata_next = serial_view.data[31:0]; // see RULE_12
        OFF_SER_HI: rdata_next = serial_view.data[63:32]; // see RULE_12
        OFF_SER_STAT: rdata_next = {24'h0, serial_view.status}; // see RULE_12
        OFF_PAGE: rdata_next = {24'h0, serial_view.page}; // see RULE_12
        default: begin
          // Six bytes a port; the unused ports 6 and 7 read zero.
          for (int p = 0; p < NPORT; p++) begin
            if (PORT_MASK[p] && bus_req.addr == 8'(OFF_LASTSA + LASTSA_STRIDE * p)) begin
              rdata_next = last_sa[p][31:0]; // see RULE_11
            end
            if (PORT_MASK[p] && bus_req.addr == 8'(OFF_LASTSA + LASTSA_STRIDE * p + LASTSA_HI)) begin
              rdata_next = {16'h0, last_sa[p][47:32]}; // see RULE_11
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the bank's own behaviour.

  a_link_read: assert property (@(posedge clk) disable iff (!nrst) // see RULE_01
    bus_req.rd && bus_req.addr == OFF_LINK |=> rdata == {23'h0, $past(st.link) & PORT_MASK})
    else $error("Link read does not match port state.");

  a_chg_sets: assert property (@(posedge clk) disable iff (!nrst) // see RULE_02
    primed_reg && link_view != link_prev_reg |=> (chg_flags & $past(link_view ^ link_prev_reg)) != 0)
    else $error("Link change did not set its flag.");

  a_chg_read_clear: assert property (@(posedge clk) disable iff (!nrst) // see RULE_02
    rd_chg && chg_set == 0 |=> chg_flags == 0)
    else $error("Reading the change flags did not clear them.");

  a_chg_after_reset: assert property (@(posedge clk) // see RULE_03
    $rose(nrst) |-> chg_flags == CHG_RESET)
    else $error("Change flags are not all ones after reset.");

  a_speed_no_turbo: assert property (@(posedge clk) disable iff (!nrst) // see RULE_06
    bus_req.rd && bus_req.addr == OFF_SPEED |=> rdata[1:0] != SPD_200 && rdata[9:8] != SPD_200)
    else $error("Rate code 11 shown on a port without turbo mode.");

  a_rsvd_speed_zero: assert property (@(posedge clk) disable iff (!nrst) // see RULE_10
    bus_req.rd && bus_req.addr == OFF_SPEED |=> rdata[31:18] == 0 && rdata[15:12] == 0)
    else $error("Unused speed bits read non-zero.");

  a_rsvd_pause_zero: assert property (@(posedge clk) disable iff (!nrst) // see RULE_10
    bus_req.rd && bus_req.addr == OFF_PAUSE
    |=> rdata[31:18] == 0 && rdata[16:15] == 0 && rdata[7:6] == 0)
    else $error("Unused pause bits read non-zero.");

  a_duplex_read: assert property (@(posedge clk) disable iff (!nrst) // see RULE_07
    bus_req.rd && bus_req.addr == OFF_DUPLEX |=> rdata[8:0] == $past(duplex_view))
    else $error("Duplex read does not match port state.");

  a_pause_layout: assert property (@(posedge clk) disable iff (!nrst) // see RULE_08
    bus_req.rd && bus_req.addr == OFF_PAUSE |=> rdata[17:9] == ($past(st.rx_pause) & PORT_MASK)
    && rdata[8:0] == ($past(st.tx_pause) & PORT_MASK))
    else $error("Pause fields out of place.");

  a_sa_sticky: assert property (@(posedge clk) disable iff (!nrst) // see RULE_13
    !rd_sachg |=> ($past(sa_flags) & ~sa_flags) == 0)
    else $error("Source change flag dropped without a read.");

  a_sa_window: assert property (@(posedge clk) disable iff (!nrst) // see RULE_11
    bus_req.rd && bus_req.addr == OFF_LASTSA |=> rdata == $past(last_sa[0][31:0]))
    else $error("Port 0 last source address misread.");

  a_page_mirror: assert property (@(posedge clk) disable iff (!nrst) // see RULE_12
    bus_req.rd && bus_req.addr == OFF_PAGE |=> rdata == {24'h0, $past(serial_view.page)})
    else $error("Page byte misread.");

  a_irq_level: assert property (@(posedge clk) disable iff (!nrst)
    irq_event != 0 && irq_mask_reg == irq_mask_next && (irq_event & irq_mask_reg) != 0 |=> irq)
    else $error("Unmasked event did not raise the interrupt.");

  // Read data fall back to zero in every cycle that does not answer a read.
  a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)
    !bus_req.rd |=> rdata == 0)
    else $error("Read data did not return to zero.");

  // Writing ones to the interrupt status drops those bits when no event competes.
  a_irq_clear: assert property (@(posedge clk) disable iff (!nrst)
    bus_req.wr && bus_req.addr == OFF_IRQ_STAT && irq_event == 0
    |=> (irq_stat_reg & $past(bus_req.wdata[IRQ_W-1:0])) == 0)
    else $error("Interrupt status bit not cleared by a write of one.");

  a_mask_write: assert property (@(posedge clk) disable iff (!nrst)
    bus_req.wr && bus_req.addr == OFF_IRQ_MASK |=> irq_mask_reg == $past(bus_req.wdata[IRQ_W-1:0]))
    else $error("Interrupt mask write did not land.");

  // Port 5 in a turbo mode must report the 200 Mbps code.
  a_speed_turbo: assert property (@(posedge clk) disable iff (!nrst) // see RULE_06
    bus_req.rd && bus_req.addr == OFF_SPEED && (st.turbo_mii_mode[0] || st.reverse_turbo_mii_mode[0])
    |=> rdata[11:10] == SPD_200)
    else $error("Turbo port 5 did not report code 11.");

  // The management port rate sits at the top pair of the speed field.
  a_mgmt_speed: assert property (@(posedge clk) disable iff (!nrst) // see RULE_04
    bus_req.rd && bus_req.addr == OFF_SPEED && !(st.turbo_mii_mode[1] || st.reverse_turbo_mii_mode[1])
    && st.speed[MGMT] != SPD_200 |=> rdata[17:16] == $past(st.speed[MGMT]))
    else $error("Management port rate out of place.");

  // A read of the source change register empties it unless a new event arrives.
  a_sa_read_clear: assert property (@(posedge clk) disable iff (!nrst) // see RULE_13
    rd_sachg && sa_set == 0 |=> sa_flags == 0)
    else $error("Reading the source change flags did not clear them.");

  c_link_change: cover property (@(posedge clk) disable iff (!nrst) |chg_set ##[1:20] rd_chg);
  c_turbo_rate: cover property (@(posedge clk) disable iff (!nrst) speed_view[11:10] == SPD_200);
  c_sa_event: cover property (@(posedge clk) disable iff (!nrst) |sa_set ##1 rd_sachg);
  c_irq_raised: cover property (@(posedge clk) disable iff (!nrst) $rose(irq));

endmodule : pssr_status_bank

`default_nettype wire

// ---- pssr_sync2.sv ----
/*
 * Two-stage synchroniser for a bus of independent levels.
 * Assumes each bit is a slow level; no coherence across bits is promised,
 * and that reset is held for at least two clock edges.
 */
`default_nettype none

module pssr_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // The first stage feeds only the second one; both keep following the pins during reset,
  // so the output already holds the live levels when reset ends and no false edge follows.
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q_reg <= meta_reg;
  end

  assign q = q_reg;
endmodule : pssr_sync2

`default_nettype wire

// ---- test_port_status_summary_regs.sv ----
/*
 * Self-checking testbench of the per-port status register bank.
 * Assumes the design package and the status bank with its helper modules are compiled first.
 */
`default_nettype none

module test_port_status_summary_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import pssr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic clk;
  logic nrst;
  pssr_bus_req_t req;
  logic [31:0] rdata;
  pssr_port_state_t ps;
  logic [8:0] nss;
  pssr_last_sa_t lsa;
  pssr_serial_view_t sv;
  logic irq;
  int err_total;
  int checks;
  logic [31:0] got;

  // The block under test.
  pssr_status_bank dut_u (
    .clk(clk),
    .nrst(nrst),
    .bus_req(req),
    .rdata(rdata),
    .port_state(ps),
    .new_source_seen(nss),
    .last_sa(lsa),
    .serial_view(sv),
    .irq(irq)
  );

  // Free-running 125 MHz clock.
  initial clk = 1'b0;
  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Compares one register word or flag and counts the outcome.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One-cycle read strobe; data is taken in the cycle after it.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask : wr

  // Lets the live state pass the synchronisers and the change logic.
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  // Reset values of the change flags, the interrupt mask and the read data.
  task automatic t_reset();
    chk("rdata idle", 32'h0, rdata);
    rd(OFF_CHG, got);
    chk("change after reset", 32'h000001FF, got);
    rd(OFF_CHG, got);
    chk("change after read", 32'h0, got);
    rd(OFF_IRQ_MASK, got);
    chk("irq mask reset", 32'h0, got);
    @(posedge clk);
    #1;
    chk("rdata after answer", 32'h0, rdata);
    $display("test reset done");
  endtask : t_reset

  // Link, duplex and pause fields, with the unused positions driven high.
  task automatic t_fields();
    @(posedge clk);
    ps.link <= 9'h1C5;
    ps.duplex <= 9'h0FA;
    ps.rx_pause <= 9'h1D3;
    ps.tx_pause <= 9'h0EC;
    settle();
    rd(OFF_LINK, got);
    chk("link", 32'h00000105, got);
    rd(OFF_DUPLEX, got);
    chk("duplex", 32'h0000003A, got);
    rd(OFF_PAUSE, got);
    chk("pause", {14'h0, 9'h113, 9'h02C}, got);
    wr(OFF_PAUSE, 32'hFFFFFFFF);
    rd(OFF_PAUSE, got);
    chk("pause kept", {14'h0, 9'h113, 9'h02C}, got);
    @(posedge clk);
    ps.tx_pause <= 9'h121;
    settle();
    rd(OFF_PAUSE, got);
    chk("pause live", {14'h0, 9'h113, 9'h121}, got);
    $display("test fields done");
  endtask : t_fields

  // Every rate code, with and without the turbo modes.
  task automatic t_speed();
    @(posedge clk);
    ps.speed <= {SPD_1000, SPD_1000, SPD_1000, SPD_100, SPD_100, SPD_1000, SPD_1000, SPD_100, SPD_10};
    ps.turbo_mii_mode <= 2'h1;
    ps.reverse_turbo_mii_mode <= 2'h2;
    settle();
    rd(OFF_SPEED, got);
    chk("speed turbo", {14'h0, SPD_200, 4'h0, SPD_200, SPD_100, SPD_1000, SPD_1000, SPD_100, SPD_10}, got);
    @(posedge clk);
    ps.turbo_mii_mode <= 2'h0;
    ps.reverse_turbo_mii_mode <= 2'h0;
    settle();
    wr(OFF_SPEED, 32'hFFFFFFFF);
    rd(OFF_SPEED, got);
    chk("speed plain", {14'h0, SPD_1000, 4'h0, SPD_100, SPD_100, SPD_1000, SPD_1000, SPD_100, SPD_10}, got);
    chk("speed reserved", 32'h0, {got[31:18], 4'h0, got[15:12]});
    $display("test speed done");
  endtask : t_speed

  // Link changes set sticky flags and the masked link interrupt.
  task automatic t_link_change();
    wr(OFF_IRQ_STAT, 32'h3);
    rd(OFF_CHG, got);
    @(posedge clk);
    ps.link <= 9'h001;
    settle();
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(OFF_IRQ_STAT, got);
    chk("irq status link", 32'h1, got);
    rd(OFF_CHG, got);
    chk("change set", 32'h00000104, got);
    rd(OFF_CHG, got);
    chk("change cleared", 32'h0, got);
    wr(OFF_IRQ_MASK, 32'h1);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(OFF_IRQ_STAT, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test link change done");
  endtask : t_link_change

  // Source address events, last addresses and the mirrored serial registers.
  task automatic t_source();
    wr(OFF_IRQ_MASK, 32'h2);
    @(posedge clk);
    nss <= 9'h121;
    @(posedge clk);
    nss <= 9'h000;
    #1;
    chk("irq source", 32'h1, {31'h0, irq});
    rd(OFF_SACHG, got);
    chk("source change", 32'h00000101, got);
    rd(OFF_SACHG, got);
    chk("source cleared", 32'h0, got);
    wr(OFF_IRQ_STAT, 32'h2);
    chk("irq source off", 32'h0, {31'h0, irq});
    rd(OFF_LASTSA + 8'h06, got);
    chk("last sa 1 low", 32'hC3D4E5F6, got);
    rd(OFF_LASTSA + 8'h34, got);
    chk("last sa 8 high", 32'h00007788, got);
    rd(OFF_SER_LO, got);
    chk("serial lo", 32'h55667788, got);
    rd(OFF_SER_HI, got);
    chk("serial hi", 32'h11223344, got);
    rd(OFF_SER_STAT, got);
    chk("serial status", 32'h000000A5, got);
    rd(OFF_PAGE, got);
    chk("page", 32'h00000001, got);
    rd(8'h50, got);
    chk("unmapped", 32'h0, got);
    $display("test source done");
  endtask : t_source

  ////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // Cuts a hang short well beyond the expected run time.
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    close_out();
  end

  // Main sequence: reset for eight cycles, then each scenario in turn.
  initial begin
    err_total = 0;
    checks = 0;
    nrst = 1'b0;
    req = '0;
    ps = '0;
    nss = 9'h000;
    lsa = '0;
    lsa[1] = 48'hA1B2C3D4E5F6;
    lsa[8] = 48'h778899AABBCC;
    sv = '{data: 64'h1122334455667788, status: 8'hA5, page: 8'h01};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_fields();
    t_speed();
    t_link_change();
    t_source();
    close_out();
  end

endmodule : test_port_status_summary_regs

`default_nettype wire
